// file: kbl_regs.svh
// Constants of the keyboard serial link: word layout, queue size, timing counts.
// Assumes a 50 MHz mclk on both ends.
`ifndef KBL_REGS_SVH
`define KBL_REGS_SVH
`define KBL_CLK_MHZ     50
`define KBL_DATA_BITS   8
`define KBL_KEY_BITS    7
`define KBL_NUM_KEYS    128
`define KBL_STOP_IDX    4'h8
`define KBL_STOP_VAL    1'b1
`define KBL_CLOSE_BIT   7
`define KBL_QDEPTH      16
`define KBL_QPTR_BITS   4
`define KBL_HOLD_EXIT   5'h08
`define KBL_SCAN_NS     1000
`define KBL_SCAN_CYC    ((`KBL_SCAN_NS * `KBL_CLK_MHZ) / 1000)
`define KBL_TMO_US      100
`define KBL_TMO_CYC     (`KBL_TMO_US * `KBL_CLK_MHZ)
`define KBL_GAP_US      40
`define KBL_GAP_CYC     (`KBL_GAP_US * `KBL_CLK_MHZ)
`define KBL_ABORT_CYC   (2 * `KBL_GAP_CYC)
`endif

// file: kbl_pkg.sv
// Types shared by both ends of the keyboard serial link.
// Assumes kbl_regs.svh for the numeric constants.
`include "kbl_regs.svh"
package kbl_pkg;
  typedef logic [`KBL_DATA_BITS-1:0] kbl_byte_t;
  typedef logic [`KBL_KEY_BITS-1:0]  kbl_key_t;
  // Keyboard sender, Gray along idle -> present -> release
  typedef enum logic [1:0] {
    KBL_K_IDLE    = 2'b00,
    KBL_K_PRESENT = 2'b01,
    KBL_K_RELEASE = 2'b11,
    KBL_K_ABORT   = 2'b10
  } kbl_kstate_t;
  // Host receiver
  typedef enum logic {
    KBL_H_WAIT = 1'b0,
    KBL_H_HELD = 1'b1
  } kbl_hstate_t;
endpackage

// file: kbl_link_if.sv
// Three-line link between keyboard and host: serial data, ready, acknowledge.
// All lines are single-direction; the testbench joins the two ends here.
`timescale 1ns/1ps
interface kbl_link_if;
  logic sd;
  logic rdy;
  logic ack;
  modport kbd (
    output sd,
    output rdy,
    input  ack
  );
  modport host (
    input  sd,
    input  rdy,
    output ack
  );
endinterface

// file: kbl_host_end.sv
// Host end of the keyboard link: acknowledges each bit and rebuilds 9-bit words.
// Assumes the keyboard end holds data stable while ready is high.
`timescale 1ns/1ps
`include "kbl_regs.svh"
module kbl_host_end (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Link
  kbl_link_if.host              lnk,
  // User side
  input  wire logic             accept_en,
  output logic                  evt_valid,
  output logic                  evt_close,
  output kbl_pkg::kbl_key_t     evt_key,
  output logic                  frame_err,
  output logic                  abandon
);
  import kbl_pkg::*;

  localparam logic [11:0] GAP_LAST = 12'(`KBL_GAP_CYC - 1);

  kbl_hstate_t st_q;
  logic [3:0]  bit_q;
  kbl_byte_t   shift_q;
  logic        stop_q;
  logic        ack_q;
  logic [11:0] gap_q;
  logic        take;
  logic        done;
  logic        gap_hit;

  // A new word starts only while the user can accept it; the keyboard retries
  assign take    = (st_q == KBL_H_WAIT) && lnk.rdy && (bit_q != 4'h0 || accept_en);
  assign done    = (st_q == KBL_H_HELD) && !lnk.rdy;
  assign gap_hit = (st_q == KBL_H_WAIT) && (bit_q != 4'h0) && !lnk.rdy && (gap_q == GAP_LAST);
  assign lnk.ack = ack_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= KBL_H_WAIT;
    end else begin
      case (st_q)
        KBL_H_WAIT: if (take) st_q <= KBL_H_HELD;
        KBL_H_HELD: if (done) st_q <= KBL_H_WAIT;
        default:    st_q <= KBL_H_WAIT;
      endcase
    end
  end

  // Ack rises when a bit is taken, falls when ready drops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else if (take) begin
      ack_q <= 1'b1;
    end else if (done) begin
      ack_q <= 1'b0;
    end
  end

  // Data bits arrive LSB first, then the stop bit
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_q <= 8'h00;
      stop_q  <= 1'b0;
    end else if (take) begin
      if (bit_q == `KBL_STOP_IDX) begin
        stop_q <= lnk.sd;
      end else begin
        shift_q <= {lnk.sd, shift_q[7:1]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bit_q <= 4'h0;
    end else if (gap_hit) begin
      bit_q <= 4'h0;
    end else if (done) begin
      bit_q <= (bit_q == `KBL_STOP_IDX) ? 4'h0 : bit_q + 4'h1;
    end
  end

  // Ready low too long inside a word means the keyboard aborted it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gap_q <= 12'h000;
    end else if (st_q == KBL_H_WAIT && bit_q != 4'h0 && !lnk.rdy) begin
      gap_q <= gap_q + 12'h001;
    end else begin
      gap_q <= 12'h000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      evt_valid <= 1'b0;
      frame_err <= 1'b0;
      abandon   <= 1'b0;
      evt_close <= 1'b0;
      evt_key   <= 7'h00;
    end else begin
      evt_valid <= done && bit_q == `KBL_STOP_IDX && stop_q == `KBL_STOP_VAL;
      frame_err <= done && bit_q == `KBL_STOP_IDX && stop_q != `KBL_STOP_VAL;
      abandon   <= gap_hit;
      if (done && bit_q == `KBL_STOP_IDX) begin
        evt_close <= shift_q[`KBL_CLOSE_BIT];
        evt_key   <= shift_q[`KBL_KEY_BITS-1:0];
      end
    end
  end
endmodule

// file: kbl_kbd_end.sv
// Keyboard end of the link: key scanner, event queue and bit-serial sender.
// Assumes key_down is synchronous to mclk and the host keeps the ack handshake.
`timescale 1ns/1ps
`include "kbl_regs.svh"
module kbl_kbd_end #(
  parameter int unsigned TMO_CYC = `KBL_TMO_CYC
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // Key matrix, one level per key, high while closed
  input  wire logic [`KBL_NUM_KEYS-1:0] key_down,
  // Link
  kbl_link_if.kbd                       lnk,
  // Status
  output logic                          holdoff,
  output logic                          retry,
  output logic                          sent
);
  import kbl_pkg::*;

  localparam int unsigned QW         = `KBL_QPTR_BITS;
  localparam logic [QW:0] QFULL      = (QW+1)'(`KBL_QDEPTH);
  localparam logic [5:0]  SCAN_LAST  = 6'(`KBL_SCAN_CYC - 1);
  localparam logic [15:0] TMO_LAST   = 16'(TMO_CYC - 1);
  localparam logic [15:0] ABORT_LAST = 16'(`KBL_ABORT_CYC - 1);

  // Queue
  kbl_byte_t   q_mem [`KBL_QDEPTH];
  logic [QW:0] wr_q;
  logic [QW:0] rd_q;
  logic [QW:0] fill;
  logic        q_empty;
  logic        q_full;
  logic        push;
  logic        pop;

  // Scanner
  logic [5:0]               div_q;
  logic                     scan_tick;
  kbl_key_t                 idx_q;
  logic [`KBL_NUM_KEYS-1:0] seen_q;
  logic                     change;

  // Sender
  kbl_kstate_t state_q;
  kbl_kstate_t state_d;
  logic [8:0]  word_q;
  logic [3:0]  bit_q;
  logic [15:0] cnt_q;
  logic        load;
  logic        step;
  logic        abort;
  logic        tmo_hit;
  logic        sd_q;
  logic        rdy_q;

  assign fill    = wr_q - rd_q;
  assign q_empty = (wr_q == rd_q);
  assign q_full  = (fill == QFULL);

  assign lnk.sd  = sd_q;
  assign lnk.rdy = rdy_q;

  // One key is examined per scan tick
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_q <= 6'h00;
    end else if (div_q == SCAN_LAST) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  assign scan_tick = (div_q == SCAN_LAST);
  assign change    = key_down[idx_q] != seen_q[idx_q];

  // Blocked change stays unreported in seen_q, so it is picked up later
  assign push = scan_tick && change && !q_full && !holdoff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      idx_q <= 7'h00;
    end else if (scan_tick) begin
      idx_q <= idx_q + 7'h01;
    end
  end

  // Last reported state of each key
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seen_q <= '0;
    end else if (push) begin
      seen_q[idx_q] <= key_down[idx_q];
    end
  end

  // Hold-off: entered on overflow, left once the queue is down to 8 entries or fewer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      holdoff <= 1'b0;
    end else if (scan_tick && change && q_full) begin
      holdoff <= 1'b1;
    end else if (fill <= `KBL_HOLD_EXIT) begin
      holdoff <= 1'b0;
    end
  end

  // Event queue; entry is close flag over key number
  always_ff @(posedge mclk) begin
    if (push) begin
      q_mem[wr_q[QW-1:0]] <= {key_down[idx_q], idx_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + (QW+1)'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + (QW+1)'(1);
    end
  end

  assign tmo_hit = (cnt_q >= TMO_LAST);

  always_comb begin
    state_d = state_q;
    load    = 1'b0;
    step    = 1'b0;
    abort   = 1'b0;
    pop     = 1'b0;
    case (state_q)
      KBL_K_IDLE: begin
        if (!q_empty) begin
          state_d = KBL_K_PRESENT;
          load    = 1'b1;
        end
      end
      KBL_K_PRESENT: begin
        if (lnk.ack) begin
          state_d = KBL_K_RELEASE;
        end else if (tmo_hit) begin
          state_d = KBL_K_ABORT;
          abort   = 1'b1;
        end
      end
      KBL_K_RELEASE: begin
        if (!lnk.ack) begin
          if (bit_q == `KBL_STOP_IDX) begin
            state_d = KBL_K_IDLE;
            pop     = 1'b1;
          end else begin
            state_d = KBL_K_PRESENT;
            step    = 1'b1;
          end
        end else if (tmo_hit) begin
          state_d = KBL_K_ABORT;
          abort   = 1'b1;
        end
      end
      KBL_K_ABORT: begin
        // Quiet gap long enough for the host to drop its partial word
        if (!lnk.ack && cnt_q >= ABORT_LAST) begin
          state_d = KBL_K_IDLE;
        end
      end
      default: state_d = KBL_K_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= KBL_K_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts time spent in the current handshake phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
    end else if (state_d != state_q || step) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Word is stop bit over the data byte; head stays queued until popped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      word_q <= 9'h000;
      bit_q  <= 4'h0;
    end else if (load) begin
      word_q <= {`KBL_STOP_VAL, q_mem[rd_q[QW-1:0]]};
      bit_q  <= 4'h0;
    end else if (step) begin
      bit_q  <= bit_q + 4'h1;
    end
  end

  // Data line changes only when a new bit is presented
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sd_q <= 1'b0;
    end else if (load) begin
      sd_q <= q_mem[rd_q[QW-1:0]][0];
    end else if (step) begin
      sd_q <= word_q[bit_q + 4'h1];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= (state_d == KBL_K_PRESENT);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      retry <= 1'b0;
      sent  <= 1'b0;
    end else begin
      retry <= abort;
      sent  <= pop;
    end
  end
endmodule

// file: kbl_link_chk.sv
// Wire checker: handshake order, bit hold, stop bit, timeout and abort gap.
// Assumes it is instantiated beside the link interface, all lines on mclk.
`timescale 1ns/1ps
`include "kbl_regs.svh"
module kbl_link_chk #(
  parameter int TMO_CYC = 200
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Link lines
  input wire logic sd,
  input wire logic rdy,
  input wire logic ack
);
  localparam int TMO_B = TMO_CYC + 2;
  localparam int GAP_MIN = `KBL_ABORT_CYC - 2;
  logic        rdy_q;
  logic        ack_q;
  logic        abort_q;
  logic [3:0]  bit_cnt_q;
  logic [15:0] low_cnt_q;
  wire         abort_ev = rdy_q && !rdy && !ack;
  wire         ack_rise = ack && !ack_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge mclk) begin
    rdy_q <= rstn && rdy;
    ack_q <= rstn && ack;
  end
  // Index of the bit being taken; a timeout restarts the word
  always_ff @(posedge mclk) begin
    if (!rstn || abort_ev) begin
      bit_cnt_q <= 4'h0;
    end else if (ack_rise) begin
      bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn || rdy) begin
      abort_q <= 1'b0;
    end else if (abort_ev) begin
      abort_q <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn || rdy) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  sequence s_offer;
    rdy && !ack;
  endsequence
  sequence s_release;
    (!rdy && ack) ##1 !ack;
  endsequence
  a_four_phase: assert property (s_offer ##1 ack |-> ##1 s_release)
    else $error("handshake phases out of order");
  a_ack_prompt: assert property ($rose(rdy) && bit_cnt_q != 4'h0 |=> ack)
    else $error("mid-word bit not acknowledged next cycle");
  a_ack_needs_rdy: assert property ($rose(ack) |-> $past(rdy))
    else $error("acknowledge without ready");
  a_rdy_drops: assert property (rdy && ack |=> !rdy)
    else $error("ready held after acknowledge");
  a_sd_held: assert property ($past(rdy) && (rdy || ack) |-> $stable(sd))
    else $error("data changed before acknowledge fell");
  a_rdy_waits_ack: assert property ($rose(rdy) |-> !ack && !$past(ack))
    else $error("next bit offered before acknowledge low");
  a_stop_bit: assert property (ack_rise && bit_cnt_q == 4'h8 |-> sd == `KBL_STOP_VAL)
    else $error("ninth bit is not a stop bit");
  a_rdy_bounded: assert property ($rose(rdy) |-> ##[1:TMO_B] !rdy)
    else $error("ready not withdrawn within timeout");
  a_abort_gap: assert property ($rose(rdy) && abort_q |-> low_cnt_q >= GAP_MIN)
    else $error("resend started before abort gap");
endmodule

// file: tb.sv
// Testbench: both link ends joined, keys driven, words checked on wire and user side.
// Assumes the design's scan order 0..127 and a short timeout parameter.
`timescale 1ns/1ps
`include "kbl_regs.svh"
module tb;
  import kbl_pkg::*;
  localparam int TMO = 200;
  logic                     mclk, rstn, accept_en;
  logic [`KBL_NUM_KEYS-1:0] key_down;
  logic                     holdoff, retry, sent, evt_valid, evt_close, frame_err, abandon;
  kbl_key_t                 evt_key;
  // Monitor state starts known without a second driver in the stimulus process
  logic                     ack_q = 1'b0;
  logic [8:0]               wire_word = 9'h000;
  logic [8:0]               got_word = 9'h000;
  int                       wire_bits = 0;
  int                       got_bits = 0;
  int                       n_fail = 0;
  int                       check_count = 0;
  logic                     retry_seen = 1'b0;
  logic                     hold_seen = 1'b0;
  logic                     junk_seen = 1'b0;
  kbl_link_if lnk ();
  kbl_kbd_end #(.TMO_CYC(TMO)) u_kbl_kbd_end (.mclk(mclk), .rstn(rstn), .key_down(key_down),
    .lnk(lnk.kbd), .holdoff(holdoff), .retry(retry), .sent(sent));
  kbl_host_end u_kbl_host_end (.mclk(mclk), .rstn(rstn), .lnk(lnk.host), .accept_en(accept_en),
    .evt_valid(evt_valid), .evt_close(evt_close), .evt_key(evt_key),
    .frame_err(frame_err), .abandon(abandon));
  kbl_link_chk #(.TMO_CYC(TMO)) u_kbl_link_chk (.mclk(mclk), .rstn(rstn), .sd(lnk.sd),
    .rdy(lnk.rdy), .ack(lnk.ack));
  // Rebuild each word from the wire, one bit per acknowledge
  always @(posedge mclk) begin
    ack_q <= lnk.ack;
    if (retry) begin
      wire_bits <= 0;
    end else if (evt_valid) begin
      got_word <= wire_word;
      got_bits <= wire_bits;
      wire_bits <= 0;
    end else if (lnk.ack && !ack_q) begin
      wire_word <= {lnk.sd, wire_word[8:1]};
      wire_bits <= wire_bits + 1;
    end
    if (retry) retry_seen <= 1'b1;
    if (holdoff) hold_seen <= 1'b1;
    if (frame_err || abandon) junk_seen <= 1'b1;
  end
  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic expect_evt(logic close, kbl_key_t key);
    for (int i = 0; i < 9000 && evt_valid !== 1'b1; i++) @(negedge mclk);
    check("evt_valid", {8'h00, evt_valid}, 9'h001);
    check("evt byte", {1'b0, evt_close, evt_key}, {1'b0, close, key});
    @(negedge mclk);
    check("evt_valid drop", {8'h00, evt_valid}, 9'h000);
    check("sent", {8'h00, sent}, 9'h001);
    check("wire bits", 9'(got_bits), 9'h009);
    check("wire word", got_word, {`KBL_STOP_VAL, close, key});
  endtask
  task automatic t_press_release();
    key_down[7'h55] = 1'b1;
    expect_evt(1'b1, 7'h55);
    key_down[7'h55] = 1'b0;
    expect_evt(1'b0, 7'h55);
  endtask
  // Scan has just passed key 55h, so 60h is reported before 70h
  task automatic t_rollover();
    key_down[7'h60] = 1'b1;
    key_down[7'h70] = 1'b1;
    expect_evt(1'b1, 7'h60);
    expect_evt(1'b1, 7'h70);
  endtask
  // Host refuses; queue fills to 16, then drains with retransmission
  task automatic t_holdoff();
    accept_en = 1'b0;
    for (int k = 0; k < 20; k++) key_down[k] = 1'b1;
    for (int i = 0; i < 10000 && !hold_seen; i++) @(negedge mclk);
    check("holdoff", {8'h00, hold_seen}, 9'h001);
    check("retry", {8'h00, retry_seen}, 9'h001);
    accept_en = 1'b1;
    for (int k = 0; k < 20; k++) expect_evt(1'b1, 7'(k));
    check("holdoff end", {8'h00, holdoff}, 9'h000);
    check("no junk", {8'h00, junk_seen}, 9'h000);
  endtask
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    accept_en = 1'b1;
    key_down = '0;
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    t_press_release();
    t_rollover();
    t_holdoff();
    final_report();
  end
endmodule
